// ===== wdt_supervisor_params.svh
// Purpose: Constants of the watchdog and reset supervisor
// Assumes: 8-bit registers on a 3-bit register address
// Notes:   Offsets, reset values, key codes and timing counts
`ifndef WDT_SUPERVISOR_PARAMS_SVH
`define WDT_SUPERVISOR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_WATCHDOG_CONTROL 3'h0
`define ADDR_RESET_CAUSE      3'h1
`define ADDR_THRESHOLD_SELECT 3'h2
`define ADDR_QUAL_TIME        3'h3
`define ADDR_STATUS           3'h4

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define RST_WATCHDOG_CONTROL  8'h57
`define RST_THRESHOLD_SELECT  8'h66
`define RST_QUAL_TIME         2'h1
`define RST_PORT              8'hff
`define KEY_MSB               7
`define KEY_LSB               3
`define PERIOD_MSB            2
`define PERIOD_LSB            0
`define FLAG_WDT_KEY          0
`define FLAG_THR_KEY          1
`define FLAG_LOW_VOLT         2
`define STATUS_TIMEOUT        0
`define STATUS_POWER_DOWN     1

// ----------------------------------------------------------------
// Key and threshold codes
// ----------------------------------------------------------------
`define KEY_ENABLE            5'h0a
`define KEY_DISABLE           5'h15
`define THR_CODE_0            8'h66
`define THR_CODE_1            8'h55
`define THR_CODE_2            8'h33
`define THR_CODE_3            8'h99
`define THR_CODE_4            8'haa
`define THR_DISABLE           8'hf0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_HZ            40000000
`define SLOW_OSC_HZ           32000
`define SLOW_DIV              (`REF_CLK_HZ / `SLOW_OSC_HZ)
`define CLK_PERIOD_NS         25
`define SWRST_DELAY_NS        45000
`define SWRST_CYCLES          ((`SWRST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_BASE              16'h0100
`define QUAL_TICKS_0          8'h08
`define QUAL_TICKS_1          8'h20
`define QUAL_TICKS_2          8'h40
`define QUAL_TICKS_3          8'h80

`endif

// ===== wdt_supervisor_pkg.sv
// Purpose: Types of the watchdog and reset supervisor
// Assumes: Nothing beyond the params header
// Notes:   Struct of state lives in the module, its widths follow parameters
package wdt_supervisor_pkg;

  // ----------------------------------------------------------------
  // Software reset sequencer
  // ----------------------------------------------------------------
  typedef enum logic {
    SEQ_IDLE,
    SEQ_DELAY
  } seq_t;

endpackage

// ===== wdt_supervisor.sv
// Purpose: Watchdog timer, keyed control and reset-cause supervision
// Assumes: CPU strobes and low-power level come from logic on REF_CLK_I
// Notes:   Low-speed oscillator is an enable pulse divided from REF_CLK_I
`timescale 1ns/1ps
`include "wdt_supervisor_params.svh"

// What this block does
// - Key 01010 enables watchdog, 10101 disables, any other key resets the chip.
// - Bad key resets after the software-reset delay and sets the key reset flag.
// - Power-on leaves the key at the enable code, so the watchdog runs.
// - Period select n gives a time-out near 2^(8+n) slow-clock periods.
// - Key reset flag is set only by a bad key and stays until cleared.
// - Overflow in normal run resets the chip and sets the time-out flag.
// - Overflow in sleep or idle sets time-out and power-down, resets only the PC via wake reset.
// - Counter clears on bad-key reset, clear instruction or halt.
// - The clear and halt instructions are the only instructions that clear the counter.
// - Counter advances on the roughly 32 kHz low-speed oscillator tick.
// - Low supply held past qualification time resets and sets the low-voltage flag.
// - Low supply shorter than the qualification time is ignored.
// - Qualification select picks 8, 32, 64 or 128 slow-clock periods.
// - Undefined threshold code resets after the delay, sets threshold-key flag.
// - Five threshold codes and f0 disable are legal; others reset and restore.
// - Threshold select powers up at 66 hex.
// - Low-voltage reset is off in sleep and every idle mode.
// - Upper five bits of the reset-cause register read zero.
// - Power-on reset forces the program counter to zero.
// - Power-on reset sets all port data and direction bits high.
module wdt_supervisor #(
  parameter int SLOW_DIV      = `SLOW_DIV,
  parameter int SWRST_CYCLES  = `SWRST_CYCLES,
  parameter int PORT_WIDTH    = 8
) (
  // Clock and power-on reset
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RSTN_I,
  // Register port
  input  wire logic [2:0]            ADDR_I,
  input  wire logic [7:0]            WDATA_I,
  input  wire logic                  WE_I,
  input  wire logic                  RE_I,
  output logic      [7:0]            RDATA_O,
  // CPU events
  input  wire logic                  CLEAR_WATCHDOG_INSTRUCTION_I,
  input  wire logic                  HALT_I,
  input  wire logic                  LOW_POWER_I,
  // Supply comparator
  input  wire logic                  LOW_SUPPLY_I,
  // Reset outputs
  output logic                       MCU_RESET_O,
  output logic                       WAKE_RESET_O,
  output logic                       PC_CLEAR_O,
  output logic      [PORT_WIDTH-1:0] PORT_DATA_O,
  output logic      [PORT_WIDTH-1:0] PORT_DIR_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int DIV_W = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
  localparam int DLY_W = $clog2(SWRST_CYCLES + 1);

  typedef struct packed {
    logic [7:0]                  wdt_ctrl;
    logic [7:0]                  thr_sel;
    logic [1:0]                  qual_sel;
    logic [2:0]                  cause;
    logic                        timeout;
    logic                        power_down;
    logic [DIV_W-1:0]            div_cnt;
    logic                        slow_tick;
    logic [14:0]                 wdt_cnt;
    logic [7:0]                  qual_cnt;
    wdt_supervisor_pkg::seq_t    seq;
    logic [DLY_W-1:0]            delay_cnt;
    logic                        wdt_key_bad;
    logic                        thr_key_bad;
    logic                        mcu_rst;
    logic                        wake_rst;
    logic                        pc_clear;
    logic [7:0]                  rdata;
    logic                        sync1;
    logic                        sync2;
    logic [PORT_WIDTH-1:0]       port_data;
    logic [PORT_WIDTH-1:0]       port_dir;
  } state_t;

  state_t q;
  state_t d;

  logic [4:0]  key;
  logic        key_bad;
  logic        thr_bad;
  logic        wdt_on;
  logic        lv_on;
  logic [14:0] wdt_limit;
  logic [7:0]  qual_limit;
  logic        wdt_overflow;
  logic        lv_fire;
  logic        swrst_fire;

  // ----------------------------------------------------------------
  // Decode of the live register values
  // ----------------------------------------------------------------
  always_comb begin
    key       = q.wdt_ctrl[`KEY_MSB:`KEY_LSB];
    key_bad   = (key != `KEY_ENABLE) && (key != `KEY_DISABLE);
    wdt_on    = (key == `KEY_ENABLE);
    thr_bad   = !((q.thr_sel == `THR_CODE_0) || (q.thr_sel == `THR_CODE_1) ||
                  (q.thr_sel == `THR_CODE_2) || (q.thr_sel == `THR_CODE_3) ||
                  (q.thr_sel == `THR_CODE_4) || (q.thr_sel == `THR_DISABLE));
    lv_on     = !thr_bad && (q.thr_sel != `THR_DISABLE) && !LOW_POWER_I;
    wdt_limit = 15'((`WDT_BASE << q.wdt_ctrl[`PERIOD_MSB:`PERIOD_LSB]) - 16'h0001);
    case (q.qual_sel)
      2'h0:    qual_limit = `QUAL_TICKS_0;
      2'h1:    qual_limit = `QUAL_TICKS_1;
      2'h2:    qual_limit = `QUAL_TICKS_2;
      default: qual_limit = `QUAL_TICKS_3;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d            = q;
    wdt_overflow = 1'b0;
    lv_fire      = 1'b0;
    swrst_fire   = 1'b0;
    d.mcu_rst    = 1'b0;
    d.wake_rst   = 1'b0;
    d.rdata      = 8'h00;
    d.sync1      = LOW_SUPPLY_I;
    d.sync2      = q.sync1;

    // Slow oscillator tick
    if (q.div_cnt == DIV_W'(SLOW_DIV - 1)) begin
      d.div_cnt   = '0;
      d.slow_tick = 1'b1;
    end else begin
      d.div_cnt   = q.div_cnt + 1'b1;
      d.slow_tick = 1'b0;
    end

    // Software writes come first so hardware sets below win
    if (WE_I) begin
      case (ADDR_I)
        `ADDR_WATCHDOG_CONTROL: d.wdt_ctrl = WDATA_I;
        `ADDR_RESET_CAUSE:      d.cause    = q.cause & WDATA_I[2:0];
        `ADDR_THRESHOLD_SELECT: d.thr_sel  = WDATA_I;
        `ADDR_QUAL_TIME:        d.qual_sel = WDATA_I[1:0];
        default:                d.cause    = d.cause;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    if (RE_I) begin
      case (ADDR_I)
        `ADDR_WATCHDOG_CONTROL: d.rdata = q.wdt_ctrl;
        `ADDR_RESET_CAUSE:      d.rdata = {5'h00, q.cause};
        `ADDR_THRESHOLD_SELECT: d.rdata = q.thr_sel;
        `ADDR_QUAL_TIME:        d.rdata = {6'h00, q.qual_sel};
        `ADDR_STATUS:           d.rdata = {6'h00, q.power_down, q.timeout};
        default:                d.rdata = 8'h00;
      endcase
    end

    // Software reset after the delay; causes are latched so a later
    // rewrite of a legal value cannot cancel a reset already owed
    case (q.seq)
      wdt_supervisor_pkg::SEQ_IDLE: begin
        if (key_bad || thr_bad) begin
          d.seq         = wdt_supervisor_pkg::SEQ_DELAY;
          d.delay_cnt   = '0;
          d.wdt_key_bad = key_bad;
          d.thr_key_bad = thr_bad;
        end
      end
      wdt_supervisor_pkg::SEQ_DELAY: begin
        d.wdt_key_bad = q.wdt_key_bad | key_bad;
        d.thr_key_bad = q.thr_key_bad | thr_bad;
        if (q.delay_cnt == DLY_W'(SWRST_CYCLES - 1)) begin
          swrst_fire    = 1'b1;
          d.mcu_rst     = 1'b1;
          d.seq         = wdt_supervisor_pkg::SEQ_IDLE;
          d.wdt_key_bad = 1'b0;
          d.thr_key_bad = 1'b0;
          if (q.wdt_key_bad || key_bad) begin
            d.cause[`FLAG_WDT_KEY] = 1'b1;
            d.wdt_ctrl             = `RST_WATCHDOG_CONTROL;
          end
          if (q.thr_key_bad || thr_bad) begin
            d.cause[`FLAG_THR_KEY] = 1'b1;
            d.thr_sel              = `RST_THRESHOLD_SELECT;
          end
        end else begin
          d.delay_cnt = q.delay_cnt + 1'b1;
        end
      end
      default: d.seq = wdt_supervisor_pkg::SEQ_IDLE;
    endcase

    // Status flags: halt sets power-down and drops time-out, clear drops both, an overflow sets time-out and, in low power, power-down
    if (HALT_I) begin
      d.power_down = 1'b1;
      d.timeout    = 1'b0;
    end
    if (CLEAR_WATCHDOG_INSTRUCTION_I) begin
      d.power_down = 1'b0;
      d.timeout    = 1'b0;
    end

    // Watchdog counter; the clear and halt instructions are its only instruction clears
    if (!wdt_on || CLEAR_WATCHDOG_INSTRUCTION_I || HALT_I || swrst_fire) begin
      d.wdt_cnt = '0;
    end else if (q.slow_tick) begin
      if (q.wdt_cnt == wdt_limit) begin
        wdt_overflow = 1'b1;
        d.wdt_cnt    = '0;
      end else begin
        d.wdt_cnt = q.wdt_cnt + 1'b1;
      end
    end

    if (wdt_overflow) begin
      d.timeout = 1'b1;
      if (LOW_POWER_I) begin
        d.power_down = 1'b1;
        d.wake_rst   = 1'b1;
      end else begin
        d.mcu_rst = 1'b1;
      end
    end

    // Low-voltage qualification: any break in the indication restarts it
    if (!lv_on || !q.sync2) begin
      d.qual_cnt = '0;
    end else if (q.slow_tick) begin
      if ((q.qual_cnt + 8'h01) == qual_limit) begin
        lv_fire                 = 1'b1;
        d.qual_cnt              = '0;
        d.mcu_rst               = 1'b1;
        d.cause[`FLAG_LOW_VOLT] = 1'b1;
        d.wdt_cnt               = '0;
      end else begin
        d.qual_cnt = q.qual_cnt + 8'h01;
      end
    end

    d.pc_clear = d.mcu_rst | d.wake_rst;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q             <= '0;
      q.wdt_ctrl    <= `RST_WATCHDOG_CONTROL;
      q.thr_sel     <= `RST_THRESHOLD_SELECT;
      q.qual_sel    <= `RST_QUAL_TIME;
      q.seq         <= wdt_supervisor_pkg::SEQ_IDLE;
      q.pc_clear    <= 1'b1;
      q.port_data   <= {PORT_WIDTH{1'b1}};
      q.port_dir    <= {PORT_WIDTH{1'b1}};
    end else begin
      q <= d;
    end
  end

  assign RDATA_O      = q.rdata;
  assign MCU_RESET_O  = q.mcu_rst;
  assign WAKE_RESET_O = q.wake_rst;
  assign PC_CLEAR_O   = q.pc_clear;
  assign PORT_DATA_O  = q.port_data;
  assign PORT_DIR_O   = q.port_dir;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  enter_delay_a: assert property (
    (q.seq == wdt_supervisor_pkg::SEQ_IDLE) && key_bad |=> (q.seq == wdt_supervisor_pkg::SEQ_DELAY)
  ) else $error("bad key did not start the reset delay");

  delay_bound_a: assert property (
    (q.seq == wdt_supervisor_pkg::SEQ_DELAY) |-> (q.delay_cnt < DLY_W'(SWRST_CYCLES))
  ) else $error("reset delay counter ran past its end");

  key_reset_flag_a: assert property (
    swrst_fire && q.wdt_key_bad |=> q.mcu_rst && q.cause[`FLAG_WDT_KEY] &&
      (q.wdt_ctrl == `RST_WATCHDOG_CONTROL) && (q.wdt_cnt == 15'h0000)
  ) else $error("bad key reset missed flag, restore or counter clear");

  key_flag_sticky_a: assert property (
    q.cause[`FLAG_WDT_KEY] && !(WE_I && (ADDR_I == `ADDR_RESET_CAUSE) && !WDATA_I[`FLAG_WDT_KEY])
      |=> q.cause[`FLAG_WDT_KEY]
  ) else $error("key reset flag dropped without a software clear");

  key_flag_cause_a: assert property (
    !q.cause[`FLAG_WDT_KEY] ##1 q.cause[`FLAG_WDT_KEY] |-> $past(swrst_fire)
  ) else $error("key reset flag set without a bad key reset");

  thr_restore_a: assert property (
    swrst_fire && thr_bad |=> q.cause[`FLAG_THR_KEY] && (q.thr_sel == `RST_THRESHOLD_SELECT) && q.mcu_rst
  ) else $error("bad threshold code was not reset and restored");

  timeout_normal_a: assert property (
    wdt_overflow && !LOW_POWER_I |=> q.mcu_rst && q.timeout && !q.wake_rst ##1 !q.mcu_rst
  ) else $error("normal overflow did not give one reset pulse with time-out");

  timeout_sleep_a: assert property (
    wdt_overflow && LOW_POWER_I |=> q.wake_rst && q.timeout && q.power_down && q.pc_clear
  ) else $error("sleep overflow did not set both flags and wake reset");

  counter_clear_a: assert property (
    (CLEAR_WATCHDOG_INSTRUCTION_I || HALT_I) |=> (q.wdt_cnt == 15'h0000)
  ) else $error("watchdog counter not cleared by clear or halt");

  period_bound_a: assert property (
    q.wdt_cnt <= wdt_limit || $changed(q.wdt_ctrl)
  ) else $error("watchdog counter passed its selected period");

  count_on_tick_a: assert property (
    !q.slow_tick && wdt_on && !CLEAR_WATCHDOG_INSTRUCTION_I && !HALT_I && !swrst_fire |=> $stable(q.wdt_cnt)
  ) else $error("watchdog counter moved without a slow tick");

  glitch_ignored_a: assert property (
    !q.sync2 |=> (q.qual_cnt == 8'h00) && !$past(lv_fire)
  ) else $error("short low supply was not ignored");

  lv_fire_a: assert property (
    lv_fire |-> (q.qual_cnt == qual_limit - 8'h01) ##1 (q.mcu_rst && q.cause[`FLAG_LOW_VOLT])
  ) else $error("low-voltage reset without full qualification or flag");

  lv_sleep_off_a: assert property (
    LOW_POWER_I |-> !lv_fire ##1 (q.qual_cnt == 8'h00)
  ) else $error("low-voltage reset active in low-power mode");

  cause_read_a: assert property (
    RE_I && (ADDR_I == `ADDR_RESET_CAUSE) |=> (RDATA_O[7:3] == 5'h00) && (RDATA_O[2:0] == $past(q.cause))
  ) else $error("reset-cause read showed upper bits or wrong flags");

  port_high_a: assert property (
    (PORT_DIR_O == {PORT_WIDTH{1'b1}}) && (PORT_DATA_O == {PORT_WIDTH{1'b1}})
  ) else $error("port registers left their power-on high state");

  swrst_cover_c:  cover property (swrst_fire ##1 q.mcu_rst);
  normal_cover_c: cover property (wdt_overflow && !LOW_POWER_I);
  sleep_cover_c:  cover property (wdt_overflow && LOW_POWER_I);
  lv_cover_c:     cover property (lv_fire);

endmodule

// ===== watchdog_and_reset_supervisor_tb.sv
// Purpose: Self-checking bench for the watchdog and reset supervisor
// Assumes: Short slow-clock divider and software-reset delay for run time
// Notes:   Expected figures come from key, period and qualification codes
`timescale 1ns/1ps
`include "wdt_supervisor_params.svh"

module watchdog_and_reset_supervisor_tb_top;
  localparam int DIV = 4;
  localparam int SR  = 4;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic       ref_clk;
  logic       rstn;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic       re;
  logic [7:0] rdata;
  logic       clear_watchdog_instruction;
  logic       halt;
  logic       low_power;
  logic       low_supply;
  logic       mcu_reset;
  logic       wake_reset;
  logic       pc_clear;
  logic [7:0] port_data;
  logic [7:0] port_dir;
  int         bad_count;
  int         comparisons;
  int         cyc;
  int         seed;

  wdt_supervisor #(.SLOW_DIV(DIV), .SWRST_CYCLES(SR), .PORT_WIDTH(8)) dut (
    .REF_CLK_I    (ref_clk),
    .RSTN_I       (rstn),
    .ADDR_I       (addr),
    .WDATA_I      (wdata),
    .WE_I         (we),
    .RE_I         (re),
    .RDATA_O      (rdata),
    .CLEAR_WATCHDOG_INSTRUCTION_I    (clear_watchdog_instruction),
    .HALT_I       (halt),
    .LOW_POWER_I  (low_power),
    .LOW_SUPPLY_I (low_supply),
    .MCU_RESET_O  (mcu_reset),
    .WAKE_RESET_O (wake_reset),
    .PC_CLEAR_O   (pc_clear),
    .PORT_DATA_O  (port_data),
    .PORT_DIR_O   (port_dir)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  function automatic bit key_ok(input logic [4:0] k);
    return (k === `KEY_ENABLE) || (k === `KEY_DISABLE);
  endfunction

  function automatic bit thr_ok(input logic [7:0] v);
    return (v === `THR_CODE_0) || (v === `THR_CODE_1) || (v === `THR_CODE_2) ||
           (v === `THR_CODE_3) || (v === `THR_CODE_4) || (v === `THR_DISABLE);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic in_range(input int n, input int lo, input int hi, input string what);
    comparisons++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("MISMATCH at %0t: %s took %0d cycles, window %0d..%0d", $time, what, n, lo, hi);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    we    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    re   <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask

  task automatic cpu_evt(input bit is_halt);
    @(posedge ref_clk);
    if (is_halt) halt <= 1'b1;
    else clear_watchdog_instruction <= 1'b1;
    @(posedge ref_clk);
    halt    <= 1'b0;
    clear_watchdog_instruction <= 1'b0;
  endtask

  // Counts edges until a reset pulse, or gives up at maxc
  task automatic wait_evt(input int maxc, output int n, output logic m, output logic w);
    n = 0;
    m = 1'b0;
    w = 1'b0;
    while (n < maxc && !m && !w) begin
      @(posedge ref_clk);
      #1;
      n++;
      m = (mcu_reset === 1'b1);
      w = (wake_reset === 1'b1);
      if (m || w) chk({7'h0, pc_clear}, 8'h01, "pc clear with reset pulse");
    end
  endtask

  task automatic done(input string name);
    $display("Test %s finished, %0d mismatches so far", name, bad_count);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int         n;
    int         t;
    logic       m;
    logic       w;
    logic [4:0] k;
    logic [7:0] v;
    logic [4:0] keys [4] = '{5'h00, 5'h1f, `KEY_ENABLE, `KEY_DISABLE};
    logic [7:0] thrs [3] = '{8'h00, 8'hff, 8'h67};
    bad_count = 0; comparisons = 0; cyc = 0; seed = 32'h1398dee6;
    rstn = 1'b0; addr = 3'h0; wdata = 8'h00; we = 1'b0; re = 1'b0;
    clear_watchdog_instruction = 1'b0; halt = 1'b0; low_power = 1'b0; low_supply = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk({7'h0, pc_clear}, 8'h01, "pc clear in reset");
    chk(port_data, 8'hff, "port data in reset");
    chk(port_dir, 8'hff, "port dir in reset");
    @(posedge ref_clk) rstn <= 1'b1;
    @(posedge ref_clk);
    #1 chk({7'h0, pc_clear}, 8'h00, "pc clear after release");
    rd(`ADDR_WATCHDOG_CONTROL, 8'h57, "control reset value");
    rd(`ADDR_RESET_CAUSE, 8'h00, "cause reset value");
    rd(`ADDR_THRESHOLD_SELECT, 8'h66, "threshold reset value");
    rd(`ADDR_QUAL_TIME, 8'h01, "qualification reset value");
    rd(`ADDR_STATUS, 8'h00, "status reset value");
    wr(`ADDR_STATUS, 8'h03);
    rd(`ADDR_STATUS, 8'h00, "status ignores writes");
    rd(3'h5, 8'h00, "unmapped read");
    done("reset_values");

    for (int i = 0; i < 8; i++) begin
      k = (i < 4) ? keys[i] : 5'($random(seed));
      wr(`ADDR_WATCHDOG_CONTROL, {k, 3'h7});
      wait_evt(SR + 3, n, m, w);
      if (key_ok(k)) begin
        chk({7'h0, m}, 8'h00, "no reset on legal key");
        rd(`ADDR_WATCHDOG_CONTROL, {k, 3'h7}, "legal key read back");
      end else begin
        in_range(m ? n : -1, SR + 1, SR + 1, "bad key reset delay");
        rd(`ADDR_RESET_CAUSE, 8'h01, "key flag set");
        rd(`ADDR_WATCHDOG_CONTROL, 8'h57, "control restored");
        wr(`ADDR_RESET_CAUSE, 8'hfe);
        rd(`ADDR_RESET_CAUSE, 8'h00, "key flag cleared by zero");
      end
    end
    wr(`ADDR_RESET_CAUSE, 8'hff);
    rd(`ADDR_RESET_CAUSE, 8'h00, "ones written leave flags clear");
    done("watchdog_key");

    for (int i = 0; i < 6; i++) begin
      v = (i < 3) ? thrs[i] : 8'($random(seed));
      wr(`ADDR_THRESHOLD_SELECT, v);
      wait_evt(SR + 3, n, m, w);
      if (thr_ok(v)) begin
        chk({7'h0, m}, 8'h00, "no reset on legal threshold");
        wr(`ADDR_THRESHOLD_SELECT, 8'h66);
      end else begin
        in_range(m ? n : -1, SR + 1, SR + 1, "bad threshold reset delay");
        rd(`ADDR_RESET_CAUSE, 8'h02, "threshold flag set");
        rd(`ADDR_THRESHOLD_SELECT, 8'h66, "threshold restored");
        wr(`ADDR_RESET_CAUSE, 8'h00);
      end
    end
    done("threshold_key");

    cpu_evt(1'b0);
    wr(`ADDR_WATCHDOG_CONTROL, 8'h50);
    cpu_evt(1'b0);
    repeat (200 * DIV) @(posedge ref_clk);
    cpu_evt(1'b0);
    wait_evt(2000, n, m, w);
    in_range(m ? n : -1, 255 * DIV, 256 * DIV + 2, "normal overflow");
    rd(`ADDR_STATUS, 8'h01, "timeout flag after overflow");
    rd(`ADDR_RESET_CAUSE, 8'h00, "overflow leaves key flag");
    @(posedge ref_clk) low_power <= 1'b1;
    cpu_evt(1'b1);
    rd(`ADDR_STATUS, 8'h02, "halt sets power down");
    wait_evt(2000, n, m, w);
    in_range(w ? n : -1, 255 * DIV - 4, 256 * DIV + 2, "low power overflow");
    rd(`ADDR_STATUS, 8'h03, "both flags after wake");
    cpu_evt(1'b0);
    rd(`ADDR_STATUS, 8'h00, "clear instruction drops flags");
    @(posedge ref_clk) low_power <= 1'b0;
    wr(`ADDR_WATCHDOG_CONTROL, 8'ha8);
    wait_evt(300 * DIV, n, m, w);
    chk({6'h0, m, w}, 8'h00, "disabled watchdog quiet");
    done("watchdog_overflow");

    wr(`ADDR_WATCHDOG_CONTROL, 8'haf);
    for (int q = 0; q < 4; q++) begin
      t = (q == 0) ? 8 : (32 << (q - 1));
      wr(`ADDR_QUAL_TIME, 8'(q));
      @(posedge ref_clk) low_supply <= 1'b1;
      repeat ((t - 2) * DIV) @(posedge ref_clk);
      low_supply <= 1'b0;
      wait_evt(2 * t * DIV, n, m, w);
      chk({7'h0, m}, 8'h00, "short low supply ignored");
      @(posedge ref_clk) low_supply <= 1'b1;
      wait_evt((t + 2) * DIV + 8, n, m, w);
      in_range(m ? n : -1, (t - 1) * DIV, (t + 1) * DIV + 4, "low voltage qualification");
      @(posedge ref_clk) low_supply <= 1'b0;
      rd(`ADDR_RESET_CAUSE, 8'h04, "low voltage flag");
      rd(`ADDR_THRESHOLD_SELECT, 8'h66, "threshold kept after low voltage");
      wr(`ADDR_RESET_CAUSE, 8'h00);
    end
    wr(`ADDR_QUAL_TIME, 8'h00);
    for (int c = 0; c < 2; c++) begin
      if (c == 0) wr(`ADDR_THRESHOLD_SELECT, `THR_DISABLE);
      else low_power <= 1'b1;
      @(posedge ref_clk) low_supply <= 1'b1;
      wait_evt(40 * DIV, n, m, w);
      chk({7'h0, m}, 8'h00, "low voltage off when disabled or asleep");
      @(posedge ref_clk) low_supply <= 1'b0;
      wr(`ADDR_THRESHOLD_SELECT, 8'h66);
    end
    low_power <= 1'b0;
    done("low_voltage");
    print_verdict();
  end
endmodule
